// ---- design/rpst_map.svh ----
// Register indices, field positions, reset values and counts for the strobes.
//
// Contract
// - Settings act only for reflective panel type.
// - Row strobe high for programmed pixel clocks.
// - First timing rises count after strobe fall.
// - Second timing first rise after latch fall.
// - Second timing holds each state programmed clocks.
// - Third timing pulse is programmed clocks wide.
// - Polarity flips programmed clocks before latch pulse.
// - First/second timing continue programmed blank lines.
`ifndef RPST_MAP_SVH
`define RPST_MAP_SVH

`define RPST_IDX_CTRL 12'h810
`define RPST_IDX_STATUS 12'h812
`define RPST_IDX_ROW_W 12'h822
`define RPST_IDX_PS1_RISE 12'h824
`define RPST_IDX_PS2_RISE 12'h826
`define RPST_IDX_PS2_TOG 12'h828
`define RPST_IDX_PS3_W 12'h82a
`define RPST_IDX_POL_LEAD 12'h82c
`define RPST_IDX_TAIL 12'h82e

`define RPST_MASK_CTRL 16'h003f
`define RPST_MASK_ROW_W 16'h07ff
`define RPST_MASK_PS1_RISE 16'h00ff
`define RPST_MASK_PS2_RISE 16'h03ff
`define RPST_MASK_PS2_TOG 16'h01ff
`define RPST_MASK_PS3_W 16'h01ff
`define RPST_MASK_POL_LEAD 16'h007f
`define RPST_MASK_TAIL 16'h001f

`define RPST_REG_RST 16'h0000

`define RPST_CTRL_TYPE_LSB 0
`define RPST_CTRL_TYPE_MSB 2
`define RPST_CTRL_SEL_BIT 3
`define RPST_CTRL_THIRD_BIT 4
`define RPST_CTRL_MIRROR_BIT 5
`define RPST_PANEL_REFLECTIVE 3'h2

`define RPST_POS_MAX 16'hffff
`define RPST_LINES_MAX 5'h1f

`endif

// ---- design/rpst_pkg.sv ----
// Shared types of the reflective panel strobe block.
`default_nettype none
package rpst_pkg;
	typedef enum logic [1:0] {
		RPST_PS_ONE,
		RPST_PS_TWO,
		RPST_PS_THREE
	} rpst_ps_mode_t;
endpackage
`default_nettype wire

// ---- design/rpst_down_timer.sv ----
// Loadable down counter that marks the last cycle of a programmed span.
`timescale 1ns/1ps
`default_nettype none
module rpst_down_timer #(
	parameter int W = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic i_clear,
	input wire logic [W-1:0] i_count,
	output logic o_busy,
	output logic o_fire
);
	typedef struct packed {
		logic [W-1:0] rem;
	} rpst_tmr_t;

	rpst_tmr_t st_q;
	rpst_tmr_t st_d;

	// A load wins over a clear so that a restart is never swallowed.
	always_comb
	begin
		st_d = st_q;
		if (i_start)
			st_d.rem = i_count;
		else if (i_clear)
			st_d.rem = '0;
		else if (st_q.rem != '0)
			st_d.rem = st_q.rem - W'(1);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign o_busy = st_q.rem != '0;
	assign o_fire = (st_q.rem == W'(1)) && !i_clear;
endmodule
`default_nettype wire

// ---- design/rpst_wb_regs.sv ----
// Classic Wishbone slave holding the strobe timing registers.
`timescale 1ns/1ps
`default_nettype none
`include "rpst_map.svh"
module rpst_wb_regs #(
	parameter int AW = 14
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [AW-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic [15:0] i_status,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output logic [15:0] o_ctrl,
	output logic [15:0] o_row_w,
	output logic [15:0] o_ps1_rise,
	output logic [15:0] o_ps2_rise,
	output logic [15:0] o_ps2_tog,
	output logic [15:0] o_ps3_w,
	output logic [15:0] o_pol_lead,
	output logic [15:0] o_tail
);
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [15:0] ctrl;
		logic [15:0] row_w;
		logic [15:0] ps1;
		logic [15:0] ps2r;
		logic [15:0] ps2t;
		logic [15:0] ps3;
		logic [15:0] pol;
		logic [15:0] tail;
	} rpst_regs_t;

	rpst_regs_t st_q;
	rpst_regs_t st_d;
	logic req;
	logic wr;
	logic [11:0] idx;
	logic [15:0] wv;

	assign req = i_wb_cyc && i_wb_stb && !st_q.ack;
	assign wr = req && i_wb_we;
	assign idx = i_wb_adr[AW-1:2];
	assign wv = i_wb_dat[15:0];

	// Only the two low byte lanes carry register bits.
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] mask);
		logic [15:0] res;
		res = old;
		if (i_wb_sel[0])
			res[7:0] = wv[7:0];
		if (i_wb_sel[1])
			res[15:8] = wv[15:8];
		return res & mask;
	endfunction

	always_comb
	begin
		st_d = st_q;
		st_d.ack = req;
		if (req)
		begin
			unique case (idx)
				`RPST_IDX_CTRL: st_d.dat = {16'h0000, st_q.ctrl};
				`RPST_IDX_STATUS: st_d.dat = {16'h0000, i_status};
				`RPST_IDX_ROW_W: st_d.dat = {16'h0000, st_q.row_w};
				`RPST_IDX_PS1_RISE: st_d.dat = {16'h0000, st_q.ps1};
				`RPST_IDX_PS2_RISE: st_d.dat = {16'h0000, st_q.ps2r};
				`RPST_IDX_PS2_TOG: st_d.dat = {16'h0000, st_q.ps2t};
				`RPST_IDX_PS3_W: st_d.dat = {16'h0000, st_q.ps3};
				`RPST_IDX_POL_LEAD: st_d.dat = {16'h0000, st_q.pol};
				`RPST_IDX_TAIL: st_d.dat = {16'h0000, st_q.tail};
				default: st_d.dat = 32'h0000_0000;
			endcase
		end
		if (wr)
		begin
			unique case (idx)
				`RPST_IDX_CTRL: st_d.ctrl = merge(st_q.ctrl, `RPST_MASK_CTRL);
				`RPST_IDX_ROW_W: st_d.row_w = merge(st_q.row_w, `RPST_MASK_ROW_W);
				`RPST_IDX_PS1_RISE: st_d.ps1 = merge(st_q.ps1, `RPST_MASK_PS1_RISE);
				`RPST_IDX_PS2_RISE: st_d.ps2r = merge(st_q.ps2r, `RPST_MASK_PS2_RISE);
				`RPST_IDX_PS2_TOG: st_d.ps2t = merge(st_q.ps2t, `RPST_MASK_PS2_TOG);
				`RPST_IDX_PS3_W: st_d.ps3 = merge(st_q.ps3, `RPST_MASK_PS3_W);
				`RPST_IDX_POL_LEAD: st_d.pol = merge(st_q.pol, `RPST_MASK_POL_LEAD);
				`RPST_IDX_TAIL: st_d.tail = merge(st_q.tail, `RPST_MASK_TAIL);
				default: st_d.tail = st_q.tail;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_q <= '0;
			st_q.ctrl <= `RPST_REG_RST;
		end
		else
			st_q <= st_d;
	end

	assign o_wb_ack = st_q.ack;
	assign o_wb_dat = st_q.dat;
	assign o_ctrl = st_q.ctrl;
	assign o_row_w = st_q.row_w;
	assign o_ps1_rise = st_q.ps1;
	assign o_ps2_rise = st_q.ps2r;
	assign o_ps2_tog = st_q.ps2t;
	assign o_ps3_w = st_q.ps3;
	assign o_pol_lead = st_q.pol;
	assign o_tail = st_q.tail;

	sequence s_wb_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence

	sequence s_wb_ans;
		o_wb_ack ##1 !o_wb_ack;
	endsequence

	AST_WB_ACK_ONE_CYCLE: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) s_wb_req |=> s_wb_ans)
		else $error("Bus answer is not a single cycle after the request.");
endmodule
`default_nettype wire

// ---- design/rpst_strobe_gen.sv ----
// Special control strobe generator for the reflective panel type.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rpst_map.svh"
module rpst_strobe_gen #(
	parameter int AW = 14,
	parameter int ROW_W = 11,
	parameter int PS1_W = 8,
	parameter int PS2R_W = 10,
	parameter int TOG_W = 9,
	parameter int LEAD_W = 7,
	parameter int TAIL_W = 5
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [AW-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_line_latch_pulse,
	input wire logic i_vdisp_active,
	input wire logic i_frame_start,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output logic o_row_strobe,
	output logic o_power_save_signal,
	output logic o_polarity_flip,
	output logic o_left_start_pulse,
	output logic o_right_start_pulse
);
	typedef struct packed {
		logic lp_prev;
		logic row;
		logic row_fall;
		logic ps;
		logic ps2_run;
		logic pol;
		logic left;
		logic right;
		logic [15:0] pos;
		logic [15:0] period;
		logic [4:0] lines;
		logic [9:0] hold;
		logic [11:0] run;
		logic [8:0] since_row;
		logic [10:0] since_lp;
	} rpst_top_t;

	rpst_top_t st_q;
	rpst_top_t st_d;

	logic [15:0] ctrl;
	logic [15:0] row_w_r;
	logic [15:0] ps1_r;
	logic [15:0] ps2r_r;
	logic [15:0] ps2t_r;
	logic [15:0] ps3_r;
	logic [15:0] lead_r;
	logic [15:0] tail_r;
	logic [15:0] status;

	logic en;
	logic mirror;
	rpst_pkg::rpst_ps_mode_t mode;
	logic lp_fall;
	logic lp_rise;
	logic ps_ok;
	logic pol_hit;
	logic row_start;
	logic row_busy;
	logic row_fire;
	logic dly_start;
	logic dly_fire;
	logic dly_now;
	logic [PS2R_W-1:0] dly_count;
	logic tog_start;
	logic tog_fire;
	logic [TOG_W-1:0] tog_count;
	logic tmr_clear;

	rpst_wb_regs #(
		.AW(AW)
	) u_regs (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr),
		.i_wb_dat(i_wb_dat),
		.i_wb_sel(i_wb_sel),
		.i_status(status),
		.o_wb_ack(o_wb_ack),
		.o_wb_dat(o_wb_dat),
		.o_ctrl(ctrl),
		.o_row_w(row_w_r),
		.o_ps1_rise(ps1_r),
		.o_ps2_rise(ps2r_r),
		.o_ps2_tog(ps2t_r),
		.o_ps3_w(ps3_r),
		.o_pol_lead(lead_r),
		.o_tail(tail_r)
	);

	assign en = ctrl[`RPST_CTRL_TYPE_MSB:`RPST_CTRL_TYPE_LSB]
		== `RPST_PANEL_REFLECTIVE;
	assign mirror = ctrl[`RPST_CTRL_MIRROR_BIT];

	always_comb
	begin
		if (ctrl[`RPST_CTRL_THIRD_BIT])
			mode = rpst_pkg::RPST_PS_THREE;
		else if (ctrl[`RPST_CTRL_SEL_BIT])
			mode = rpst_pkg::RPST_PS_TWO;
		else
			mode = rpst_pkg::RPST_PS_ONE;
	end

	assign lp_fall = st_q.lp_prev && !i_line_latch_pulse;
	assign lp_rise = !st_q.lp_prev && i_line_latch_pulse;

	assign ps_ok = en && ((mode == rpst_pkg::RPST_PS_THREE) ? i_vdisp_active
		: (i_vdisp_active || (st_q.lines <= tail_r[TAIL_W-1:0])));

	assign pol_hit = (st_q.period > {{(16-LEAD_W){1'b0}}, lead_r[LEAD_W-1:0]})
		&& ((st_q.pos + 16'h0001) == (st_q.period
		- {{(16-LEAD_W){1'b0}}, lead_r[LEAD_W-1:0]}));

	assign status = {3'h0, st_q.lines, 4'h0, st_q.pol, st_q.ps, st_q.row, en};

	assign row_start = en && lp_fall;

	rpst_down_timer #(
		.W(ROW_W)
	) u_row_tmr (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_start(row_start),
		.i_clear(!en),
		.i_count(row_w_r[ROW_W-1:0]),
		.o_busy(row_busy),
		.o_fire(row_fire)
	);

	assign tmr_clear = !ps_ok || lp_rise;

	// First timing counts from the strobe fall.
	// Second timing counts from the latch fall.
	assign dly_start = ps_ok && !lp_rise
		&& (((mode == rpst_pkg::RPST_PS_ONE) && st_q.row_fall)
		|| ((mode == rpst_pkg::RPST_PS_TWO) && lp_fall));
	assign dly_count = (mode == rpst_pkg::RPST_PS_ONE)
		? {{(PS2R_W-PS1_W){1'b0}}, ps1_r[PS1_W-1:0]} : ps2r_r[PS2R_W-1:0];
	// A zero delay rises at once, since the timer holds at zero and never fires on a zero load.
	assign dly_now = dly_fire || (dly_start && (dly_count == '0));

	rpst_down_timer #(
		.W(PS2R_W)
	) u_dly_tmr (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_start(dly_start),
		.i_clear(tmr_clear),
		.i_count(dly_count),
		.o_busy(),
		.o_fire(dly_fire)
	);

	assign tog_start = ps_ok && !lp_rise
		&& (((mode == rpst_pkg::RPST_PS_TWO)
		&& (dly_now || (tog_fire && st_q.ps2_run)))
		|| ((mode == rpst_pkg::RPST_PS_THREE) && st_q.row_fall));
	assign tog_count = (mode == rpst_pkg::RPST_PS_THREE)
		? ps3_r[TOG_W-1:0] : ps2t_r[TOG_W-1:0];

	rpst_down_timer #(
		.W(TOG_W)
	) u_tog_tmr (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_start(tog_start),
		.i_clear(tmr_clear),
		.i_count(tog_count),
		.o_busy(),
		.o_fire(tog_fire)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.lp_prev = i_line_latch_pulse;
		st_d.row = en && row_busy;
		st_d.row_fall = en && (row_fire
			|| (row_start && (row_w_r[ROW_W-1:0] == '0)));
		st_d.left = en && i_frame_start && !mirror;
		st_d.right = en && i_frame_start && mirror;
		// Count lines spent in the blank period.
		if (!en || i_vdisp_active)
			st_d.lines = '0;
		else if (lp_fall && (st_q.lines != `RPST_LINES_MAX))
			st_d.lines = st_q.lines + 5'h01;
		// Measure the line and flip ahead of the latch.
		if (!en)
		begin
			st_d.pos = '0;
			st_d.period = '0;
			st_d.pol = 1'b0;
		end
		else
		begin
			if (lp_rise)
			begin
				st_d.period = st_q.pos;
				st_d.pos = 16'h0001;
			end
			else if (st_q.pos != `RPST_POS_MAX)
				st_d.pos = st_q.pos + 16'h0001;
			if (pol_hit)
				st_d.pol = !st_q.pol;
		end
		// A new line ends every saving state of the previous one.
		if (!ps_ok || lp_rise)
		begin
			st_d.ps = 1'b0;
			st_d.ps2_run = 1'b0;
		end
		else
		begin
			unique case (mode)
				rpst_pkg::RPST_PS_ONE:
				begin
					if (dly_now)
						st_d.ps = 1'b1;
				end
				rpst_pkg::RPST_PS_TWO:
				begin
					if (dly_now)
					begin
						st_d.ps = 1'b1;
						st_d.ps2_run = 1'b1;
					end
					else if (tog_fire && st_q.ps2_run)
						st_d.ps = !st_q.ps;
				end
				rpst_pkg::RPST_PS_THREE:
				begin
					if (st_q.row_fall && (ps3_r[TOG_W-1:0] != '0))
						st_d.ps = 1'b1;
					else if (tog_fire)
						st_d.ps = 1'b0;
				end
				default: st_d.ps = 1'b0;
			endcase
		end
		st_d.hold = (st_d.ps != st_q.ps) ? 10'h001
			: ((st_q.hold == 10'h3ff) ? st_q.hold : st_q.hold + 10'h001);
		st_d.run = st_q.row ? st_q.run + 12'h001 : 12'h000;
		st_d.since_row = (st_q.row && !st_d.row) ? 9'h000
			: ((st_q.since_row == 9'h1ff) ? st_q.since_row
			: st_q.since_row + 9'h001);
		st_d.since_lp = lp_fall ? 11'h000
			: ((st_q.since_lp == 11'h7ff) ? st_q.since_lp
			: st_q.since_lp + 11'h001);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign o_row_strobe = st_q.row;
	assign o_power_save_signal = st_q.ps;
	assign o_polarity_flip = st_q.pol;
	assign o_left_start_pulse = st_q.left;
	assign o_right_start_pulse = st_q.right;

	AST_OFF_WHEN_OTHER_PANEL: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) !en |=> !o_row_strobe && !o_power_save_signal
		&& !o_polarity_flip && !o_left_start_pulse && !o_right_start_pulse)
		else $error("Strobe active while another panel type is chosen.");

	AST_ROW_WIDTH: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) $fell(o_row_strobe) && en && $past(en)
		|-> st_q.run == {1'b0, row_w_r[ROW_W-1:0]})
		else $error("Row strobe width differs from the programmed width.");

	AST_PS1_RISE: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) $rose(o_power_save_signal) && en
		&& (mode == rpst_pkg::RPST_PS_ONE) && (row_w_r[ROW_W-1:0] != '0)
		|-> st_q.since_row == {1'b0, ps1_r[PS1_W-1:0]})
		else $error("First timing rise is not at the programmed offset.");

	AST_PS2_FIRST_RISE: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) $rose(o_power_save_signal) && en
		&& (mode == rpst_pkg::RPST_PS_TWO) && !$past(st_q.ps2_run)
		|-> st_q.since_lp == {1'b0, ps2r_r[PS2R_W-1:0]})
		else $error("Second timing first rise is not at the programmed offset.");

	AST_PS2_HOLD: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) en && (mode == rpst_pkg::RPST_PS_TWO)
		&& tog_fire && st_q.ps2_run && ps_ok && !lp_rise
		|-> st_q.hold == {1'b0, ps2t_r[TOG_W-1:0]} ##1 $changed(o_power_save_signal))
		else $error("Second timing state held for a wrong number of clocks.");

	AST_PS3_WIDTH: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) en && (mode == rpst_pkg::RPST_PS_THREE)
		&& tog_fire && st_q.ps && ps_ok && !lp_rise
		|-> st_q.hold == {1'b0, ps3_r[TOG_W-1:0]} ##1 !o_power_save_signal)
		else $error("Third timing pulse width differs from the setting.");

	AST_POL_LEAD: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) $changed(o_polarity_flip) && en && $past(en)
		|-> ({1'b0, st_q.pos} + {10'h000, lead_r[LEAD_W-1:0]})
		== {1'b0, st_q.period})
		else $error("Polarity flip is not at the programmed lead.");

	AST_TAIL_END: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) en && !i_vdisp_active
		&& (st_q.lines > tail_r[TAIL_W-1:0]) |=> !o_power_save_signal)
		else $error("Power save runs past the programmed blank lines.");

	sequence s_frame_go;
		en && i_frame_start;
	endsequence

	AST_MIRROR_PULSE: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b) s_frame_go |=> (o_left_start_pulse
		== !$past(mirror)) && (o_right_start_pulse == $past(mirror)))
		else $error("Start pulse sent on the wrong side for the mirror bit.");
endmodule
`default_nettype wire

// ---- sim/rpst_line_src.sv ----
// Line and frame timing source that feeds the strobe block in the bench.
`timescale 1ns/1ps
`default_nettype none
module rpst_line_src #(
	parameter int LINE = 40,
	parameter int HI = 2,
	parameter int DISP = 4,
	parameter int LINES = 10
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	output logic o_line_latch_pulse,
	output logic o_vdisp_active,
	output logic o_frame_start
);
	typedef struct packed {
		logic [7:0] pos;
		logic [3:0] ln;
	} rpst_src_state_t;
	rpst_src_state_t st_q;
	rpst_src_state_t st_d;
	always_comb
	begin
		st_d = st_q;
		st_d.pos = st_q.pos + 8'h01;
		if (st_q.pos == 8'(LINE - 1))
		begin
			st_d.pos = 8'h00;
			st_d.ln = (st_q.ln == 4'(LINES - 1)) ? 4'h0 : st_q.ln + 4'h1;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	// Blank lines keep their latch pulses, as a real panel timing does.
	assign o_line_latch_pulse = (st_q.pos < 8'(HI));
	assign o_vdisp_active = (st_q.ln < 4'(DISP));
	assign o_frame_start = (st_q.pos == 8'h00) && (st_q.ln == 4'h0);
endmodule
`default_nettype wire

// ---- sim/rpst_strobe_gen_test.sv ----
// Self-checking bench for the reflective panel strobe generator.
`timescale 1ns/1ps
`default_nettype none
`include "rpst_map.svh"
module rpst_strobe_gen_test;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [13:0] adr = 14'h0000;
	logic [31:0] wdat = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic ack, latch, vdisp, fstart, row, ps, pol, left, right;
	logic [31:0] rdat;
	logic [31:0] got;
	logic p_latch = 1'b0, p_row = 1'b0, p_ps = 1'b0, p_pol = 1'b0;
	logic first_r = 1'b0, first_f = 1'b0;
	int n_errors = 0;
	int checks_done = 0;
	int cyc_n = 0, t_lf = 0, t_rr = 0, t_rf = 0, t_pr = 0, t_pol = 0;
	int d_row_lf, d_row_w, d_ps_lf, d_ps_rf, d_ps_w, d_pol;
	int n_hi = 0, n_left = 0, n_right = 0, n_blank = 0;
	always #5 clk_sys = ~clk_sys;
	rpst_strobe_gen rpst_strobe_gen_i (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.i_line_latch_pulse(latch), .i_vdisp_active(vdisp),
		.i_frame_start(fstart), .o_wb_ack(ack), .o_wb_dat(rdat),
		.o_row_strobe(row), .o_power_save_signal(ps), .o_polarity_flip(pol),
		.o_left_start_pulse(left), .o_right_start_pulse(right)
	);
	rpst_line_src rpst_line_src_i (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .o_line_latch_pulse(latch),
		.o_vdisp_active(vdisp), .o_frame_start(fstart)
	);
	// Deltas are kept as events happen, so a check never depends on where
	// in the line it lands.
	always @(posedge clk_sys)
	begin
		cyc_n++;
		n_hi += int'(row) + int'(ps) + int'(pol) + int'(left) + int'(right);
		n_left += int'(left);
		n_right += int'(right);
		if (ps && !p_ps && !vdisp)
			n_blank++;
		if (p_latch && !latch)
		begin
			t_lf = cyc_n;
			first_r = 1'b1;
			first_f = 1'b1;
		end
		if (!p_latch && latch)
			d_pol = cyc_n - t_pol;
		if (pol !== p_pol)
			t_pol = cyc_n;
		if (row && !p_row)
		begin
			t_rr = cyc_n;
			d_row_lf = cyc_n - t_lf;
		end
		if (!row && p_row)
		begin
			t_rf = cyc_n;
			d_row_w = cyc_n - t_rr;
		end
		if (ps && !p_ps && first_r)
		begin
			t_pr = cyc_n;
			d_ps_lf = cyc_n - t_lf;
			d_ps_rf = cyc_n - t_rf;
			first_r = 1'b0;
		end
		if (!ps && p_ps && first_f)
		begin
			d_ps_w = cyc_n - t_pr;
			first_f = 1'b0;
		end
		{p_latch, p_row, p_ps, p_pol} = {latch, row, ps, pol};
	end
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] idx,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {16'h0000, d};
		sel <= 4'h3;
		@(posedge clk_sys);
		while (ack !== 1'b1)
		begin
			n++;
			@(posedge clk_sys);
		end
		got = rdat;
		chk("bus ack latency", n, 1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic lines(input int n);
		repeat (n * 40) @(posedge clk_sys);
	endtask
	task automatic t_regs();
		logic [11:0] idx [8] = '{`RPST_IDX_ROW_W, `RPST_IDX_PS1_RISE,
			`RPST_IDX_PS2_RISE, `RPST_IDX_PS2_TOG, `RPST_IDX_PS3_W,
			`RPST_IDX_POL_LEAD, `RPST_IDX_TAIL, 12'h900};
		logic [15:0] msk [8] = '{16'h07ff, 16'h00ff, 16'h03ff, 16'h01ff,
			16'h01ff, 16'h007f, 16'h001f, 16'h0000};
		for (int i = 0; i < 8; i++)
		begin
			wb(1'b0, idx[i], 16'h0000);
			chk("reset value", got, 32'h0);
			wb(1'b1, idx[i], 16'hffff);
			wb(1'b0, idx[i], 16'h0000);
			chk("field width", got, {16'h0, msk[i]});
		end
	endtask
	task automatic t_disabled();
		wb(1'b1, `RPST_IDX_ROW_W, 16'h0005);
		wb(1'b1, `RPST_IDX_PS1_RISE, 16'h0003);
		wb(1'b1, `RPST_IDX_PS2_RISE, 16'h0004);
		wb(1'b1, `RPST_IDX_PS2_TOG, 16'h0003);
		wb(1'b1, `RPST_IDX_PS3_W, 16'h0006);
		wb(1'b1, `RPST_IDX_POL_LEAD, 16'h0004);
		wb(1'b1, `RPST_IDX_TAIL, 16'h0000);
		wb(1'b1, `RPST_IDX_CTRL, 16'h003b);
		lines(2);
		n_hi = 0;
		lines(12);
		chk("outputs off", n_hi, 0);
	endtask
	task automatic t_first();
		wb(1'b1, `RPST_IDX_CTRL, 16'h0002);
		lines(12);
		chk("row start", d_row_lf, 2);
		chk("row width", d_row_w, 5);
		chk("first rise", d_ps_rf, 3);
		chk("flip lead", d_pol, 4);
	endtask
	task automatic t_second();
		wb(1'b1, `RPST_IDX_CTRL, 16'h000a);
		lines(12);
		chk("second rise", d_ps_lf, 5);
		chk("second toggle", d_ps_w, 3);
	endtask
	task automatic t_third();
		wb(1'b1, `RPST_IDX_CTRL, 16'h001a);
		lines(12);
		chk("third start", d_ps_rf, 0);
		chk("third width", d_ps_w, 6);
		wb(1'b1, `RPST_IDX_TAIL, 16'h0003);
		n_blank = 0;
		lines(10);
		chk("third blank", n_blank, 0);
	endtask
	task automatic t_tail();
		int cnt [3];
		wb(1'b1, `RPST_IDX_CTRL, 16'h0002);
		for (int i = 0; i < 3; i++)
		begin
			wb(1'b1, `RPST_IDX_TAIL, 16'(2 * i));
			lines(10);
			n_blank = 0;
			lines(10);
			cnt[i] = n_blank;
		end
		chk("tail zero", cnt[0], 0);
		chk("tail two", cnt[1], 2);
		chk("tail lines", cnt[2] - cnt[1], 2);
	endtask
	task automatic t_mirror();
		wb(1'b1, `RPST_IDX_CTRL, 16'h0002);
		n_left = 0;
		n_right = 0;
		lines(10);
		chk("normal left", n_left, 1);
		chk("normal right", n_right, 0);
		wb(1'b1, `RPST_IDX_CTRL, 16'h0022);
		n_left = 0;
		n_right = 0;
		lines(10);
		chk("mirror left", n_left, 0);
		chk("mirror right", n_right, 1);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#200us;
		n_errors++;
		end_sim();
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_regs();
		t_disabled();
		t_first();
		t_second();
		t_third();
		t_tail();
		t_mirror();
		end_sim();
	end
endmodule
`default_nettype wire
